// ### addr_map_cfg.svh
// Address map constants for the code/data address decoder
`ifndef ADDR_MAP_CFG_SVH
`define ADDR_MAP_CFG_SVH

`define WAIT_CTRL_OFS       8'ha7
`define WAIT_CTRL_RESET     8'h00
`define RT_WAIT_EN_BIT      0
`define WAIT_CLK_EN_BIT     1
`define CODE_ROM_BASE       24'hff0000
`define CODE_ROM_LAST       24'hff7fff
`define CODE_PREFETCH_LO    24'hff7ff8
`define SEG_FF_LAST         24'hffffff
`define SEG_FE_LAST         24'hfeffff
`define SEG_01_LAST         24'h01ffff
`define RESET_VECTOR        24'hff0000
`define SEG_00_BASE         24'h000000
`define REG_AREA_LAST       24'h00001f
`define RAM_BASE            24'h000020
`define RAM_LAST            24'h00041f
`define BIT_AREA_LO         24'h000020
`define BIT_AREA_HI         24'h0000ff
`define MIRROR_LO           24'h00c000
`define MIRROR_HI           24'h00ffff
`define MIRROR_EXT_BASE     24'hff4000
`define RD_RANGE_64K        2'h3

`endif

// ### addr_map_pkg.sv
// Types shared by the address decoder
package addr_map_pkg;

    typedef enum logic [1:0] {
        TGT_EXTERNAL = 2'b00,
        TGT_ROM      = 2'b01,
        TGT_RAM      = 2'b10,
        TGT_REGFILE  = 2'b11
    } target_t;

    typedef struct packed {
        logic        code_space;
        logic        is_fetch;
        logic [23:0] addr;
    } access_t;

    typedef struct packed {
        target_t     target;
        logic [23:0] local_addr;
        logic        bit_addressable;
        logic        prefetch_hazard;
    } decode_t;

endpackage

// ### code_data_address_map.sv
// Code and data address decoder with PC wrap, page-mode muxing and wait support
// What this block does
// - With external access high, 32 KB ROM sits at bottom of FF:, rest external.
// - With external access low, every code fetch goes external.
// - Fetches from the last eight ROM bytes may prefetch externally above FF:7FFF.
// - PC passing end of FF: wraps to FF:0000.
// - PC passing end of FE: continues at FF:0000.
// - PC passing end of 01: wraps to start of 00:.
// - 1 KB data RAM sits just above the 32-byte register area.
// - RAM from 20h to FFh is bit addressable.
// - Code-space accesses never reach data RAM.
// - Mirror bit cleared maps upper 16 KB of ROM into top of region 00:.
// - Mirror with external access low goes to FF:4000-FF:7FFF externally.
// - Mirror bit set hides ROM from region 00:.
// - Data accesses with no on-chip memory go external.
// - Page mode: port 0 low address, port 2 high address and data.
// - Real-time wait enable lets the wait input stretch bus cycles.
// - Wait clock enable gives half-oscillator square wave on wait clock pin.
// - Program-store strobe asserted over range picked by two read-range bits.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "addr_map_cfg.svh"
module code_data_address_map
    import addr_map_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Configuration levels
    input  wire logic        external_access_select_n,
    input  wire logic        code_mirror_disable,
    input  wire logic        read_range_select_lo,
    input  wire logic        read_range_select_hi,
    input  wire logic        page_mode,
    // Core access request
    input  wire logic        acc_valid,
    input  wire access_t     acc,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_wdata,
    // Program counter increment
    input  wire logic        pc_step,
    input  wire logic [23:0] pc_in,
    output logic      [23:0] pc_next,
    // Decode result
    output decode_t          dec,
    output logic             ext_cycle,
    output logic             bus_stall,
    // External bus pins
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    output logic      [7:0]  port2_out,
    output logic             port2_oe,
    output logic             program_store_strobe_n,
    input  wire logic        wait_n,
    output logic             wait_clk
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic decode_t decode(input access_t r, input logic ea_n,
                                       input logic mirror_off);
        decode_t d;
        d = '{target: TGT_EXTERNAL, local_addr: r.addr, bit_addressable: 1'b0,
              prefetch_hazard: 1'b0};
        if (r.code_space) begin
            // Data RAM never visible here
            if (ea_n && in_range(r.addr, `CODE_ROM_BASE, `CODE_ROM_LAST)) begin
                d.target     = TGT_ROM;
                d.local_addr = r.addr - `CODE_ROM_BASE;
                // Only instruction fetches prefetch past the ROM end
                d.prefetch_hazard = r.is_fetch &&
                    in_range(r.addr, `CODE_PREFETCH_LO, `CODE_ROM_LAST);
            end
            // External access low leaves target external
        end else begin
            if (r.addr <= `REG_AREA_LAST) begin
                d.target = TGT_REGFILE;
            end else if (in_range(r.addr, `RAM_BASE, `RAM_LAST)) begin
                d.target          = TGT_RAM;
                d.local_addr      = r.addr - `RAM_BASE;
                d.bit_addressable = in_range(r.addr, `BIT_AREA_LO, `BIT_AREA_HI);
            end else if (!mirror_off && in_range(r.addr, `MIRROR_LO, `MIRROR_HI)) begin
                if (ea_n) begin
                    d.target     = TGT_ROM;
                    d.local_addr = r.addr - `MIRROR_LO + (`MIRROR_EXT_BASE - `CODE_ROM_BASE);
                end else begin
                    d.local_addr = r.addr - `MIRROR_LO + `MIRROR_EXT_BASE;
                end
            end
            // Mirror set or unmapped: stays external
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational decode, no added bus cycles

    decode_t next_dec;
    always_comb begin
        next_dec = decode(acc, external_access_select_n, code_mirror_disable);
    end

    logic [23:0] next_pc;
    always_comb begin
        next_pc = pc_in + 24'h000001;
        if (pc_in == `SEG_FF_LAST) begin
            next_pc = `RESET_VECTOR;
        end else if (pc_in == `SEG_FE_LAST) begin
            next_pc = `RESET_VECTOR;
        end else if (pc_in == `SEG_01_LAST) begin
            next_pc = `SEG_00_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait state control register

    logic [7:0] wait_state_control;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_state_control <= `WAIT_CTRL_RESET;
        end else if (reg_wr && reg_addr == `WAIT_CTRL_OFS) begin
            wait_state_control <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= (reg_addr == `WAIT_CTRL_OFS) ? wait_state_control : 8'h00;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    logic realtime_wait_enable;
    logic wait_clock_enable;
    assign realtime_wait_enable = wait_state_control[`RT_WAIT_EN_BIT];
    assign wait_clock_enable    = wait_state_control[`WAIT_CLK_EN_BIT];

    wait_clk_div u_wait_clk (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .enable   (wait_clock_enable),
        .wait_clk (wait_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic ext_now;
    assign ext_now = acc_valid && next_dec.target == TGT_EXTERNAL;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dec       <= '{target: TGT_EXTERNAL, local_addr: 24'h000000,
                           bit_addressable: 1'b0, prefetch_hazard: 1'b0};
            ext_cycle <= 1'b0;
        end else begin
            dec       <= next_dec;
            ext_cycle <= ext_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pc_next <= `RESET_VECTOR;
        end else if (pc_step) begin
            pc_next <= next_pc;
        end
    end

    // Stretch only external cycles, and only when enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_stall <= 1'b0;
        end else begin
            bus_stall <= realtime_wait_enable && ext_now && !wait_n;
        end
    end

    // Read-range select, external code space only: 11 and 10 strobe every access, 01 only with addr[16] low, 00 only with addr[17] low
    logic strobe_hit;
    always_comb begin
        strobe_hit = 1'b0;
        if (ext_now && acc.code_space) begin
            case ({read_range_select_hi, read_range_select_lo})
                `RD_RANGE_64K: strobe_hit = 1'b1;
                2'h2:          strobe_hit = 1'b1;
                2'h1:          strobe_hit = !acc.addr[16];
                2'h0:          strobe_hit = !acc.addr[17];
                default:       strobe_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            program_store_strobe_n <= 1'b1;
        end else begin
            program_store_strobe_n <= !strobe_hit;
        end
    end

    // Page mode keeps address low bits on port 0 for the whole cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port0_out <= 8'h00;
            port0_oe  <= 1'b0;
            port2_out <= 8'h00;
            port2_oe  <= 1'b0;
        end else if (ext_now) begin
            port0_out <= page_mode ? acc.addr[7:0] :
                         (acc_write ? acc_wdata : acc.addr[7:0]);
            port0_oe  <= page_mode || acc_write || 1'b1;
            port2_out <= (page_mode && acc_write) ? acc_wdata : acc.addr[15:8];
            port2_oe  <= 1'b1;
        end else begin
            port0_oe  <= 1'b0;
            port2_oe  <= 1'b0;
        end
    end

endmodule

// ### code_data_address_map_checker.sv
// Assertion checker for the code/data address decoder
`timescale 1ns/100ps
module code_data_address_map_checker
    import addr_map_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        external_access_select_n,
    input wire logic        code_mirror_disable,
    input wire access_t     acc,
    input wire logic        pc_step,
    input wire logic [23:0] pc_in,
    input wire logic [23:0] pc_next,
    input wire decode_t     dec,
    input wire logic        wait_clk
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic in_rom;
    logic data_acc;
    assign in_rom = acc.addr inside {[24'hff0000:24'hff7fff]};
    assign data_acc = !acc.code_space;
    ////////////////////////////////////////////////////////////////////////////
    rom_map_a: assert property (acc.code_space && external_access_select_n && in_rom
        |=> dec.target == TGT_ROM) else $error("on-chip code fetch not decoded to rom");
    ea_low_a: assert property (acc.code_space && !external_access_select_n
        |=> dec.target == TGT_EXTERNAL) else $error("code fetch not external");
    pc_ff_a: assert property (pc_step && pc_in == 24'hffffff
        |=> pc_next == 24'hff0000) else $error("pc wrap in ff failed");
    pc_fe_a: assert property (pc_step && pc_in == 24'hfeffff
        |=> pc_next == 24'hff0000) else $error("pc step past fe failed");
    pc_01_a: assert property (pc_step && pc_in == 24'h01ffff
        |=> pc_next == 24'h000000) else $error("pc wrap in 01 failed");
    pc_plain_a: assert property (pc_step && pc_in[15:0] != 16'hffff
        |=> pc_next == $past(pc_in) + 24'h1) else $error("pc increment wrong");
    code_ram_a: assert property (acc.code_space
        |=> dec.target != TGT_RAM) else $error("code access reached data ram");
    ram_map_a: assert property (data_acc && acc.addr inside {[24'h20:24'h41f]}
        |=> dec.target == TGT_RAM) else $error("ram window misdecoded");
    bit_area_a: assert property (data_acc && acc.addr inside {[24'h20:24'hff]}
        |=> dec.bit_addressable) else $error("bit area not flagged");
    mirror_off_a: assert property (data_acc && code_mirror_disable
        && acc.addr inside {[24'hc000:24'hffff]} |=> dec.target == TGT_EXTERNAL)
        else $error("rom visible with mirror off");
    wclk_a: assert property (wait_clk |=> !wait_clk) else $error("wait clock stuck high");
    cover property (pc_step && pc_in == 24'hffffff);
    cover property (dec.target == TGT_ROM);
    cover property (wait_clk);
endmodule

// ### ext_mem_model.sv
// Slow external memory that stretches bus cycles through the wait input
`timescale 1ns/100ps
module ext_mem_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ext_cycle,
    input  wire logic slow,
    output logic      wait_n
);
    logic [1:0] hold;
    // Two-clock stretch per external cycle when slow
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            hold <= 2'h0;
        else if (slow && ext_cycle && hold == 2'h0)
            hold <= 2'h2;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end
    assign wait_n = (hold == 2'h0);
endmodule

// ### tb_code_data_address_map.sv
// Self-checking testbench for the code/data address decoder
`timescale 1ns/100ps
module tb_code_data_address_map;
    import addr_map_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        external_access_select_n = 1'b1, code_mirror_disable = 1'b1, page_mode = 1'b0;
    logic        read_range_select_lo = 1'b1, read_range_select_hi = 1'b1, slow = 1'b0;
    logic        acc_valid = 1'b0, acc_write = 1'b0, pc_step = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, acc_wdata = 8'h00;
    logic [7:0]  reg_rdata, port0_out, port2_out, q;
    logic [23:0] pc_in = 24'h000000, pc_next;
    access_t     acc = '0;
    decode_t     dec;
    logic        ext_cycle, bus_stall, port0_oe, port2_oe, program_store_strobe_n, wait_n, wait_clk;
    int          failures = 0, num_checks = 0;
    always #20 core_clk = ~core_clk;
    code_data_address_map DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .external_access_select_n, .code_mirror_disable, .read_range_select_lo,
        .read_range_select_hi, .page_mode, .acc_valid, .acc, .acc_write, .acc_wdata, .pc_step,
        .pc_in, .pc_next, .dec, .ext_cycle, .bus_stall, .port0_out, .port0_oe, .port2_out,
        .port2_oe, .program_store_strobe_n, .wait_n, .wait_clk);
    ext_mem_model mem (.core_clk, .rst_n, .ext_cycle, .slow, .wait_n);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic dec_chk(input logic ea, cmd, cs, input logic [23:0] a, input target_t t);
        @(posedge core_clk);
        external_access_select_n <= ea;
        code_mirror_disable <= cmd;
        acc <= '{code_space: cs, is_fetch: cs, addr: a};
        acc_valid <= 1'b1;
        @(posedge core_clk);
        #1 chk(dec.target, t);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        reg_acc(1'b0, 8'ha7, 8'h00);
        chk(q, 8'h00);
        reg_acc(1'b1, 8'ha7, 8'h03);
        reg_acc(1'b0, 8'ha7, 8'h00);
        chk(q, 8'h03);
        reg_acc(1'b0, 8'h10, 8'h00);
        chk(q, 8'h00);
        $display("regs test done");
    endtask
    task automatic t_code();
        dec_chk(1, 1, 1, 24'hff0010, TGT_ROM);
        chk(dec.local_addr, 24'h0010);
        dec_chk(1, 1, 1, 24'hff8000, TGT_EXTERNAL);
        dec_chk(1, 1, 1, 24'hfe0000, TGT_EXTERNAL);
        dec_chk(1, 1, 1, 24'hff7ff8, TGT_ROM);
        chk(dec.prefetch_hazard, 1'b1);
        dec_chk(1, 1, 1, 24'hff7ff7, TGT_ROM);
        chk(dec.prefetch_hazard, 1'b0);
        dec_chk(1, 1, 1, 24'h000020, TGT_EXTERNAL);
        dec_chk(0, 1, 1, 24'hff0010, TGT_EXTERNAL);
        chk(program_store_strobe_n, 1'b0);
        dec_chk(1, 1, 0, 24'h000420, TGT_EXTERNAL);
        chk(program_store_strobe_n, 1'b1);
        $display("code test done");
    endtask
    task automatic t_data();
        dec_chk(1, 1, 0, 24'h00001f, TGT_REGFILE);
        dec_chk(1, 1, 0, 24'h000020, TGT_RAM);
        chk(dec.bit_addressable, 1'b1);
        dec_chk(1, 1, 0, 24'h000100, TGT_RAM);
        chk(dec.bit_addressable, 1'b0);
        dec_chk(1, 1, 0, 24'h00041f, TGT_RAM);
        dec_chk(1, 0, 0, 24'h00c000, TGT_ROM);
        chk(dec.local_addr, 24'h4000);
        dec_chk(0, 0, 0, 24'h00ffff, TGT_EXTERNAL);
        chk(dec.local_addr, 24'hff7fff);
        dec_chk(1, 1, 0, 24'h00c000, TGT_EXTERNAL);
        $display("data test done");
    endtask
    task automatic t_pc();
        logic [23:0] tab [4][2] = '{'{24'hffffff, 24'hff0000}, '{24'hfeffff, 24'hff0000},
                                    '{24'h01ffff, 24'h000000}, '{24'h00ffff, 24'h010000}};
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            pc_in <= tab[i][0];
            pc_step <= 1'b1;
            @(posedge core_clk);
            pc_step <= 1'b0;
            #1 chk(pc_next, tab[i][1]);
        end
        $display("pc test done");
    endtask
    task automatic t_wait();
        slow <= 1'b1;
        dec_chk(0, 1, 1, 24'hfe0000, TGT_EXTERNAL);
        for (int i = 0; i < 10 && bus_stall !== 1'b1; i++)
            @(posedge core_clk) #1;
        chk(bus_stall, 1'b1);
        if (bus_stall !== 1'b1)
            test_done();
        q[0] = wait_clk;
        @(posedge core_clk) #1;
        chk(wait_clk, !q[0]);
        @(posedge core_clk) #1;
        chk(wait_clk, q[0]);
        slow <= 1'b0;
        $display("wait test done");
    endtask
    task automatic t_page();
        page_mode <= 1'b1;
        acc_write <= 1'b1;
        acc_wdata <= 8'h5a;
        dec_chk(1, 1, 0, 24'h001234, TGT_EXTERNAL);
        chk(port0_out, 8'h34);
        chk(port2_out, 8'h5a);
        chk(port0_oe, 1'b1);
        chk(port2_oe, 1'b1);
        chk(ext_cycle, 1'b1);
        acc_valid <= 1'b0;
        acc_write <= 1'b0;
        $display("page test done");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_code();
        t_data();
        t_pc();
        t_wait();
        t_page();
        test_done();
    end
endmodule
bind code_data_address_map code_data_address_map_checker u_chk (.core_clk, .rst_n,
    .external_access_select_n, .code_mirror_disable, .acc, .pc_step, .pc_in, .pc_next,
    .dec, .wait_clk);

// ### wait_clk_div.sv
// Half-rate wait clock generator
`timescale 1ns/100ps
module wait_clk_div (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    output logic      wait_clk
);
    // Toggles each cycle, giving half the oscillator rate
    always_ff @(posedge core_clk) begin
        if (!rst_n || !enable) begin
            wait_clk <= 1'b0;
        end else begin
            wait_clk <= ~wait_clk;
        end
    end
endmodule
